// ===== hdl/dcd_consts.svh
// Notes on behaviour
// - each command comes only from CS, ACT, shared pins, A10, CKE at this and the previous edge, and the held power state.
// - ACT high makes shared pins command bits; ACT low makes them row bits 16..14.
// - bank group, bank, row and column widths are parameters of the decoder.
// - bank commands target one bank chosen by bank group and bank address.
// - mode set picks the mode register from group and bank bits, opcode from address.
// - the device reset is active low and purely asynchronous.
// - a started read or write burst always runs to its end.
// - the reserved A17 bit is never used during a mode set.
// - termination pin never alters decode; termination is off in self refresh.
// - self refresh exit is made synchronous by the controller; detected synchronously.
// - no internal refresh happens while in power-down.
// - column access: write or read, A10 auto precharge, A12 chop when on the fly.
// - reserved code performs no defined action.
`ifndef DCD_CONSTS_SVH
`define DCD_CONSTS_SVH

// ****************************************
// field widths at their largest
// ****************************************
`define DCD_BG_MAX 2
`define DCD_BA_MAX 2
`define DCD_ROW_MAX 17
`define DCD_COL_MAX 10
`define DCD_ADDR_W 14
`define DCD_MR_SEL_W 3
`define DCD_OPCODE_W 14

// ****************************************
// address pin positions
// ****************************************
`define DCD_AP_BIT 10
`define DCD_BC_BIT 12

// ****************************************
// burst occupancy in link clocks
// ****************************************
`define DCD_BURST_W 3
`define DCD_BURST_CK 3'h4

`endif

// ===== hdl/dcd_pkg.sv
package dcd_pkg;
`include "dcd_consts.svh"

  // decoded command codes
  typedef enum logic [4:0] {
    DCD_CMD_NONE = 5'h00,
    DCD_CMD_DES = 5'h01,
    DCD_CMD_NOP = 5'h02,
    DCD_CMD_MODE_SET = 5'h03,
    DCD_CMD_REFRESH = 5'h04,
    DCD_CMD_SREF_IN = 5'h05,
    DCD_CMD_SREF_OUT = 5'h06,
    DCD_CMD_PDOWN_IN = 5'h07,
    DCD_CMD_PDOWN_OUT = 5'h08,
    DCD_CMD_PRECH = 5'h09,
    DCD_CMD_PRECH_ALL = 5'h0A,
    DCD_CMD_ACTIVATE = 5'h0B,
    DCD_CMD_WRITE = 5'h0C,
    DCD_CMD_READ = 5'h0D,
    DCD_CMD_ZQ_LONG = 5'h0E,
    DCD_CMD_ZQ_SHORT = 5'h0F,
    DCD_CMD_RESERVED = 5'h10,
    DCD_CMD_ILLEGAL = 5'h11
  } dcd_cmd_t;

  // power state of the device
  typedef enum logic [1:0] {
    DCD_PM_ACTIVE = 2'b00,
    DCD_PM_PDOWN = 2'b01,
    DCD_PM_SREF = 2'b10
  } dcd_pm_t;

  // burst length mode held by the mode registers
  typedef enum logic [1:0] {
    DCD_BL_FIXED8 = 2'b00,
    DCD_BL_OTF = 2'b01,
    DCD_BL_FIXED4 = 2'b10
  } dcd_bl_t;

  // command and address pins as sampled at the link clock edge
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic act_n;
    logic ras_n_a16;
    logic cas_n_a15;
    logic we_n_a14;
    logic [`DCD_BG_MAX-1:0] bg;
    logic [`DCD_BA_MAX-1:0] ba;
    logic [`DCD_ADDR_W-1:0] addr;
    logic odt;
  } dcd_pins_t;

  // one decoded command
  typedef struct packed {
    dcd_cmd_t code;
    logic [`DCD_BG_MAX-1:0] bg;
    logic [`DCD_BA_MAX-1:0] ba;
    logic [`DCD_ROW_MAX-1:0] row;
    logic [`DCD_COL_MAX-1:0] col;
    logic auto_pre;
    logic chop4;
    logic [`DCD_MR_SEL_W-1:0] mr_sel;
    logic [`DCD_OPCODE_W-1:0] opcode;
  } dcd_cmd_rec_t;

  // mode set word handed to the system side
  typedef struct packed {
    logic [`DCD_MR_SEL_W-1:0] mr_sel;
    logic [`DCD_OPCODE_W-1:0] opcode;
  } dcd_mode_word_t;

endpackage

// ===== hdl/dcd_sync.sv
`timescale 1ns/1ps
module dcd_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [W-1:0] d, // levels from the other domain
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ****************************************
  // two-stage synchroniser
  // ****************************************
  // the first stage feeds only the second, so nothing sees a metastable value
  always_comb begin
    next_meta = d;
    next_q = meta;
    if (sys_rst) begin
      next_meta = '0;
      next_q = '0;
    end
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule

// ===== hdl/dcd_decoder.sv
`timescale 1ns/1ps
`include "dcd_consts.svh"
module dcd_decoder #(
  parameter int BG_W = `DCD_BG_MAX, // bank group bits used
  parameter int BA_W = `DCD_BA_MAX, // bank bits used
  parameter int ROW_W = `DCD_ROW_MAX, // row bits used
  parameter int COL_W = `DCD_COL_MAX // column bits used
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // system reset, synchronous, active high
  input wire logic ck, // link clock from the controller
  input wire logic reset_n, // device reset, asynchronous, active low
  input dcd_pkg::dcd_pins_t pins, // command and address pins
  input dcd_pkg::dcd_bl_t burst_mode, // burst length mode
  output logic cmd_valid, // one link cycle per decoded command
  output dcd_pkg::dcd_cmd_rec_t cmd, // decoded command
  output dcd_pkg::dcd_pm_t pm_state, // power state
  output logic odt_en, // termination enable
  output logic burst_busy, // burst in progress
  output logic refresh_pulse, // start one refresh
  output logic sys_self_refresh, // self refresh, system clock
  output logic sys_power_down, // power-down, system clock
  output logic sys_mrs_pulse, // mode set seen, system clock
  output dcd_pkg::dcd_mode_word_t sys_mode_word // last mode set word
);
  import dcd_pkg::*;

  // unused upper field bits are forced to zero
  localparam logic [`DCD_BG_MAX-1:0] BG_MASK = `DCD_BG_MAX'((1 << BG_W) - 1);
  localparam logic [`DCD_BA_MAX-1:0] BA_MASK = `DCD_BA_MAX'((1 << BA_W) - 1);
  localparam logic [`DCD_ROW_MAX-1:0] ROW_MASK = `DCD_ROW_MAX'((1 << ROW_W) - 1);
  localparam logic [`DCD_COL_MAX-1:0] COL_MASK = `DCD_COL_MAX'((1 << COL_W) - 1);

  // ****************************************
  // link domain state
  // ****************************************
  logic cke_prev;
  dcd_pm_t pm;
  logic [`DCD_BURST_W-1:0] burst_cnt;
  dcd_mode_word_t mrs_hold;
  logic mrs_toggle;
  dcd_cmd_rec_t rec;
  dcd_pm_t next_pm;
  logic [`DCD_BURST_W-1:0] next_burst_cnt;
  dcd_mode_word_t next_mrs_hold;
  logic next_mrs_toggle;
  logic [2:0] cmd_bits;
  logic next_cmd_valid;
  logic next_odt_en;
  logic next_burst_busy;
  logic next_refresh_pulse;

  assign cmd_bits = {pins.ras_n_a16, pins.cas_n_a15, pins.we_n_a14};

  // ****************************************
  // command decode
  // ****************************************
  // only cke, cs, act, the shared pins, A10 and the held power state choose the command; odt is not read here
  always_comb begin
    rec = '0;
    rec.code = DCD_CMD_NONE;
    next_pm = pm;
    unique case ({cke_prev, pins.cke})
      2'b11: begin
        if (pins.cs_n) begin
          rec.code = DCD_CMD_DES;
        end else if (!pins.act_n) begin
          // shared pins become row bits 16..14
          rec.code = DCD_CMD_ACTIVATE;
          rec.bg = pins.bg & BG_MASK;
          rec.ba = pins.ba & BA_MASK;
          rec.row = {cmd_bits, pins.addr} & ROW_MASK;
        end else begin
          unique case (cmd_bits)
            3'b000: begin
              rec.code = DCD_CMD_MODE_SET;
              rec.mr_sel = {pins.bg[0], pins.ba};
              rec.opcode = pins.addr;
            end
            3'b001: rec.code = DCD_CMD_REFRESH;
            3'b010: begin
              if (pins.addr[`DCD_AP_BIT]) begin
                rec.code = DCD_CMD_PRECH_ALL;
              end else begin
                rec.code = DCD_CMD_PRECH;
                rec.bg = pins.bg & BG_MASK;
                rec.ba = pins.ba & BA_MASK;
              end
            end
            3'b011: rec.code = DCD_CMD_RESERVED;
            3'b100, 3'b101: begin
              rec.code = pins.we_n_a14 ? DCD_CMD_READ : DCD_CMD_WRITE;
              rec.bg = pins.bg & BG_MASK;
              rec.ba = pins.ba & BA_MASK;
              rec.col = pins.addr[`DCD_COL_MAX-1:0] & COL_MASK;
              rec.auto_pre = pins.addr[`DCD_AP_BIT];
              // chop only follows A12 when the length is chosen on the fly
              rec.chop4 = (burst_mode == DCD_BL_FIXED4) ||
                          ((burst_mode == DCD_BL_OTF) && !pins.addr[`DCD_BC_BIT]);
            end
            3'b110: begin
              rec.code = pins.addr[`DCD_AP_BIT] ? DCD_CMD_ZQ_LONG : DCD_CMD_ZQ_SHORT;
            end
            3'b111: rec.code = DCD_CMD_NOP;
          endcase
        end
      end
      2'b10: begin
        if (pins.cs_n) begin
          rec.code = DCD_CMD_PDOWN_IN;
          next_pm = DCD_PM_PDOWN;
        end else if (pins.act_n && cmd_bits == 3'b001) begin
          rec.code = DCD_CMD_SREF_IN;
          next_pm = DCD_PM_SREF;
        end else begin
          rec.code = DCD_CMD_ILLEGAL;
        end
      end
      2'b01: begin
        // exit is taken at the rising edge, synchronously
        if (pm == DCD_PM_SREF &&
            (pins.cs_n || (pins.act_n && cmd_bits == 3'b111))) begin
          rec.code = DCD_CMD_SREF_OUT;
          next_pm = DCD_PM_ACTIVE;
        end else if (pm == DCD_PM_PDOWN && pins.cs_n) begin
          rec.code = DCD_CMD_PDOWN_OUT;
          next_pm = DCD_PM_ACTIVE;
        end else if (pm != DCD_PM_ACTIVE) begin
          rec.code = DCD_CMD_ILLEGAL;
        end
      end
      2'b00: rec.code = DCD_CMD_NONE; // power state held, pins ignored
    endcase
  end

  // ****************************************
  // burst, mode word and toggle next values
  // ****************************************
  // a new column command reloads; nothing else can cut a burst short
  always_comb begin
    next_burst_cnt = burst_cnt;
    if (rec.code == DCD_CMD_READ || rec.code == DCD_CMD_WRITE) begin
      next_burst_cnt = `DCD_BURST_CK;
    end else if (burst_cnt != '0) begin
      next_burst_cnt = burst_cnt - `DCD_BURST_W'(1);
    end
    next_mrs_hold = mrs_hold;
    next_mrs_toggle = mrs_toggle;
    if (rec.code == DCD_CMD_MODE_SET) begin
      next_mrs_hold = {rec.mr_sel, rec.opcode};
      next_mrs_toggle = !mrs_toggle;
    end
    next_cmd_valid = (rec.code != DCD_CMD_NONE);
    next_odt_en = pins.odt && (next_pm != DCD_PM_SREF);
    next_burst_busy = (next_burst_cnt != '0);
    // refresh only from the active state, never inside power-down
    next_refresh_pulse = (rec.code == DCD_CMD_REFRESH) && (pm == DCD_PM_ACTIVE);
  end

  // device reset takes every link flop to a constant at once
  always_ff @(posedge ck or negedge reset_n) begin
    if (!reset_n) begin
      cke_prev <= 1'b0;
      pm <= DCD_PM_ACTIVE;
      burst_cnt <= '0;
      mrs_hold <= '0;
      mrs_toggle <= 1'b0;
      cmd_valid <= 1'b0;
      cmd <= '0;
      pm_state <= DCD_PM_ACTIVE;
      odt_en <= 1'b0;
      burst_busy <= 1'b0;
      refresh_pulse <= 1'b0;
    end else begin
      cke_prev <= pins.cke;
      pm <= next_pm;
      burst_cnt <= next_burst_cnt;
      mrs_hold <= next_mrs_hold;
      mrs_toggle <= next_mrs_toggle;
      cmd_valid <= next_cmd_valid;
      cmd <= rec;
      pm_state <= next_pm;
      odt_en <= next_odt_en;
      burst_busy <= next_burst_busy;
      refresh_pulse <= next_refresh_pulse;
    end
  end

  // ****************************************
  // crossing to the system clock
  // ****************************************
  logic [2:0] sync_q;
  logic toggle_seen;
  logic next_toggle_seen;
  logic next_sys_mrs_pulse;
  dcd_mode_word_t next_sys_mode_word;
  logic next_sys_self_refresh;
  logic next_sys_power_down;

  dcd_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({mrs_toggle, pm == DCD_PM_PDOWN, pm == DCD_PM_SREF}),
    .q(sync_q)
  );

  // the mode word is only sampled after its toggle has crossed, so it is stable;
  // limitation: two mode sets closer than one system clock can cancel out; closer than three, both pulses can carry the later word
  always_comb begin
    next_toggle_seen = sync_q[2];
    next_sys_mrs_pulse = sync_q[2] ^ toggle_seen;
    next_sys_self_refresh = sync_q[0];
    next_sys_power_down = sync_q[1];
    next_sys_mode_word = sys_mode_word;
    if (next_sys_mrs_pulse) begin
      next_sys_mode_word = mrs_hold;
    end
    if (sys_rst) begin
      next_toggle_seen = 1'b0;
      next_sys_mrs_pulse = 1'b0;
      next_sys_self_refresh = 1'b0;
      next_sys_power_down = 1'b0;
      next_sys_mode_word = '0;
    end
  end

  always_ff @(posedge clk) begin
    toggle_seen <= next_toggle_seen;
    sys_mrs_pulse <= next_sys_mrs_pulse;
    sys_mode_word <= next_sys_mode_word;
    sys_self_refresh <= next_sys_self_refresh;
    sys_power_down <= next_sys_power_down;
  end

  // ****************************************
  // checks
  // ****************************************
  logic live;
  assign live = cke_prev && pins.cke && !pins.cs_n;

  sequence s_column_pins;
    live && pins.act_n && pins.ras_n_a16 && !pins.cas_n_a15;
  endsequence

  sequence s_mode_pins;
    live && pins.act_n && cmd_bits == 3'b000;
  endsequence

  property p_mode_set;
    @(posedge ck) disable iff (!reset_n)
    s_mode_pins |=> cmd_valid && cmd.code == DCD_CMD_MODE_SET &&
      cmd.mr_sel == $past({pins.bg[0], pins.ba}) && cmd.opcode == $past(pins.addr);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode set decoded wrong");

  property p_activate_row;
    @(posedge ck) disable iff (!reset_n)
    (live && !pins.act_n) |=> cmd.code == DCD_CMD_ACTIVATE &&
      cmd.row[16:14] == $past(cmd_bits) && cmd.bg == $past(pins.bg);
  endproperty
  a_activate_row: assert property (p_activate_row) else $error("activate row wrong");

  property p_column;
    @(posedge ck) disable iff (!reset_n)
    s_column_pins |=> (cmd.code == (($past(pins.we_n_a14)) ? DCD_CMD_READ : DCD_CMD_WRITE)) &&
      cmd.auto_pre == $past(pins.addr[`DCD_AP_BIT]);
  endproperty
  a_column: assert property (p_column) else $error("column access wrong");

  property p_burst_runs;
    @(posedge ck) disable iff (!reset_n)
    s_column_pins |=> burst_busy [*4];
  endproperty
  a_burst_runs: assert property (p_burst_runs) else $error("burst cut short");

  property p_odt_off_sref;
    @(posedge ck) disable iff (!reset_n)
    pm_state == DCD_PM_SREF |-> !odt_en;
  endproperty
  a_odt_off_sref: assert property (p_odt_off_sref) else $error("odt on in self refresh");

  property p_reserved;
    @(posedge ck) disable iff (!reset_n)
    (live && pins.act_n && cmd_bits == 3'b011) |=>
      cmd.code == DCD_CMD_RESERVED && !refresh_pulse && $stable(pm_state);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  property p_pdown_entry;
    @(posedge ck) disable iff (!reset_n)
    (cke_prev && !pins.cke && pins.cs_n) |=>
      cmd.code == DCD_CMD_PDOWN_IN && pm_state == DCD_PM_PDOWN;
  endproperty
  a_pdown_entry: assert property (p_pdown_entry) else $error("power-down entry missed");

  property p_no_refresh_pdown;
    @(posedge ck) disable iff (!reset_n)
    refresh_pulse |-> $past(pm) == DCD_PM_ACTIVE;
  endproperty
  a_no_refresh_pdown: assert property (p_no_refresh_pdown) else $error("refresh in pd");

  property p_sref_entry;
    @(posedge ck) disable iff (!reset_n)
    (cke_prev && !pins.cke && !pins.cs_n && pins.act_n && cmd_bits == 3'b001) |=>
      cmd.code == DCD_CMD_SREF_IN ##1 (pm_state == DCD_PM_SREF || cmd_valid);
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("self refresh entry missed");

  property p_zq;
    @(posedge ck) disable iff (!reset_n)
    (live && pins.act_n && cmd_bits == 3'b110) |=>
      cmd.code == (($past(pins.addr[`DCD_AP_BIT])) ? DCD_CMD_ZQ_LONG : DCD_CMD_ZQ_SHORT);
  endproperty
  a_zq: assert property (p_zq) else $error("zq decode wrong");

  property p_deselect;
    @(posedge ck) disable iff (!reset_n)
    (cke_prev && pins.cke && pins.cs_n) |=> cmd.code == DCD_CMD_DES && cmd.bg == '0;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect decode wrong");
endmodule

// ===== bench/dcd_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************
// controller side of the command bus
// ****************************************
module dcd_ctrl_model (
  input wire logic ck, // link clock
  output dcd_pkg::dcd_pins_t pins // command and address pins
);
  import dcd_pkg::*;

  // power-up: deselected with clock enable low
  initial begin
    pins = '0;
    pins.cs_n = 1'b1;
  end

  // one command, launched off the falling edge so the rising edge sees settled levels
  task automatic send(input dcd_pins_t p);
    @(negedge ck);
    pins <= p;
  endtask

  // deselect cycles; cke moves only at a falling edge, so exits stay synchronous
  // don't-care pins flip each cycle so nothing leans on stale levels
  // gaps are always filled with deselect, never with no-operation
  task automatic idle(input logic cke, input int n);
    repeat (n) begin
      @(negedge ck);
      // one assignment per cycle: cke, cs_n high, flipped don't-cares, odt kept
      pins <= {cke, 1'b1, ~pins[22:1], pins.odt};
    end
  endtask
endmodule

// ===== bench/ddr4_command_decoder_test.sv
`timescale 1ns/1ps
module ddr4_command_decoder_test;
  import dcd_pkg::*;

  logic clk, sys_rst, ck, reset_n, cmd_valid, odt_en, burst_busy, refresh_pulse;
  logic sys_self_refresh, sys_power_down, sys_mrs_pulse;
  dcd_pins_t pins;
  dcd_bl_t burst_mode;
  dcd_cmd_rec_t cmd;
  dcd_pm_t pm_state;
  dcd_mode_word_t sys_mode_word;
  int error_cnt = 0;
  int compares = 0;

  // ****************************************
  // clocks, design and controller model
  // ****************************************
  // link clock offset so its edges never line up with the system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #3.1;
    forever #6 ck = ~ck;
  end

  dcd_decoder DUT (.clk(clk), .sys_rst(sys_rst), .ck(ck), .reset_n(reset_n), .pins(pins),
    .burst_mode(burst_mode), .cmd_valid(cmd_valid), .cmd(cmd), .pm_state(pm_state),
    .odt_en(odt_en), .burst_busy(burst_busy), .refresh_pulse(refresh_pulse),
    .sys_self_refresh(sys_self_refresh), .sys_power_down(sys_power_down),
    .sys_mrs_pulse(sys_mrs_pulse), .sys_mode_word(sys_mode_word));

  dcd_ctrl_model ctl (.ck(ck), .pins(pins));

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ctl6 is {cke, cs_n, act_n, ras/a16, cas/a15, we/a14}, bgba is {bg, ba}
  function automatic dcd_pins_t mk(input logic [5:0] ctl6, input logic [3:0] bgba,
                                   input logic [13:0] addr, input logic odt);
    return {ctl6, bgba, addr, odt};
  endfunction

  // outputs are looked at just after the edge that sampled the pins
  task automatic issue(input dcd_pins_t p);
    ctl.send(p);
    @(posedge ck);
    #1;
  endtask

  task automatic des(input logic cke);
    ctl.idle(cke, 1);
    @(posedge ck);
    #1;
  endtask

  task automatic code_is(input string what, input dcd_cmd_t c);
    check({what, " code"}, cmd.code, c);
    check({what, " valid"}, cmd_valid, c != DCD_CMD_NONE);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_bank();
    issue(mk(6'b100101, 4'h9, 14'h2A5C, 1'b0));
    code_is("act", DCD_CMD_ACTIVATE);
    check("act row", cmd.row, 17'h16A5C);
    check("act bank", {cmd.bg, cmd.ba}, 4'h9);
    issue(mk(6'b101010, 4'h6, 14'h0000, 1'b1));
    code_is("pre", DCD_CMD_PRECH);
    check("pre bank", {cmd.bg, cmd.ba}, 4'h6);
    issue(mk(6'b101010, 4'h6, 14'h0400, 1'b0));
    code_is("prea", DCD_CMD_PRECH_ALL);
    issue(mk(6'b101001, 4'h0, 14'h1234, 1'b0));
    code_is("ref", DCD_CMD_REFRESH);
    check("ref pulse", refresh_pulse, 1'b1);
    issue(mk(6'b101011, 4'h0, 14'h0000, 1'b0));
    code_is("rfu", DCD_CMD_RESERVED);
    check("rfu pulse", refresh_pulse, 1'b0);
    check("rfu state", pm_state, DCD_PM_ACTIVE);
    issue(mk(6'b101110, 4'h0, 14'h0400, 1'b0));
    code_is("zql", DCD_CMD_ZQ_LONG);
    issue(mk(6'b101110, 4'h0, 14'h0000, 1'b0));
    code_is("zqs", DCD_CMD_ZQ_SHORT);
    des(1'b1);
    code_is("des", DCD_CMD_DES);
  endtask

  // back-to-back write and read, then a precharge that must not cut the burst short
  task automatic t_burst();
    int n;
    @(negedge ck);
    burst_mode <= DCD_BL_OTF;
    issue(mk(6'b101100, 4'hC, 14'h06B7, 1'b0));
    code_is("wr", DCD_CMD_WRITE);
    check("wr fields", {cmd.bg, cmd.ba, cmd.col, cmd.auto_pre, cmd.chop4}, 16'hCADF);
    issue(mk(6'b101101, 4'h7, 14'h13C1, 1'b0));
    code_is("rd", DCD_CMD_READ);
    check("rd fields", {cmd.bg, cmd.ba, cmd.col, cmd.auto_pre, cmd.chop4}, 16'h7F04);
    n = burst_busy;
    issue(mk(6'b101010, 4'h7, 14'h0000, 1'b0));
    n += burst_busy;
    repeat (6) begin
      des(1'b1);
      n += burst_busy;
    end
    check("burst length", n, 4);
    for (int i = 0; i < 2; i++) begin
      @(negedge ck);
      burst_mode <= i ? DCD_BL_FIXED8 : DCD_BL_FIXED4;
      issue(mk(6'b101101, 4'h0, i ? 14'h0000 : 14'h1000, 1'b0));
      check("fixed chop", cmd.chop4, !i);
    end
  endtask

  // the pulse must cross exactly once and carry the word with it
  task automatic t_mode_set();
    int seen = 0;
    issue(mk(6'b101000, 4'h6, 14'h3C96, 1'b1));
    code_is("mrs", DCD_CMD_MODE_SET);
    check("mrs select", cmd.mr_sel, 3'h6);
    check("mrs opcode", cmd.opcode, 14'h3C96);
    check("mrs odt", odt_en, 1'b1);
    fork
      ctl.idle(1'b1, 60);
      repeat (20) begin
        @(posedge clk);
        #1;
        seen += sys_mrs_pulse;
      end
    join
    check("mrs pulses", seen, 1);
    check("mrs word", sys_mode_word, 17'h1BC96);
  endtask

  task automatic t_power_down();
    des(1'b0);
    code_is("pde", DCD_CMD_PDOWN_IN);
    check("pde state", pm_state, DCD_PM_PDOWN);
    issue(mk(6'b001001, 4'h0, 14'h0000, 1'b0));
    code_is("pd hold", DCD_CMD_NONE);
    check("pd refresh", refresh_pulse, 1'b0);
    ctl.idle(1'b0, 50);
    check("sys pd", sys_power_down, 1'b1);
    des(1'b1);
    code_is("pdx", DCD_CMD_PDOWN_OUT);
    check("pdx state", pm_state, DCD_PM_ACTIVE);
    ctl.idle(1'b1, 50);
    check("sys pd off", sys_power_down, 1'b0);
  endtask

  // termination asked for throughout, yet it must stay off while in self refresh
  task automatic t_self_refresh();
    issue(mk(6'b001001, 4'h0, 14'h0000, 1'b1));
    code_is("sre", DCD_CMD_SREF_IN);
    check("sre state", pm_state, DCD_PM_SREF);
    check("sre odt", odt_en, 1'b0);
    ctl.idle(1'b0, 50);
    check("sys sr", sys_self_refresh, 1'b1);
    des(1'b1);
    code_is("srx", DCD_CMD_SREF_OUT);
    check("srx state", pm_state, DCD_PM_ACTIVE);
    ctl.idle(1'b1, 50);
    check("sys sr off", sys_self_refresh, 1'b0);
  endtask

  // device reset in mid-run clears state without waiting for a link edge
  task automatic t_async_reset();
    des(1'b0);
    @(negedge ck);
    reset_n <= 1'b0;
    #1;
    check("rst state", pm_state, DCD_PM_ACTIVE);
    check("rst valid", cmd_valid, 1'b0);
    @(negedge ck);
    reset_n <= 1'b1;
    des(1'b1);
    check("rst first", cmd_valid, 1'b0);
    des(1'b1);
    code_is("rst des", DCD_CMD_DES);
  endtask

  // ****************************************
  // sequence, watchdog and verdict
  // ****************************************
  task automatic conclude();
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    reset_n = 1'b0;
    burst_mode = DCD_BL_FIXED8;
    repeat (10) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    @(negedge ck);
    reset_n <= 1'b1;
    des(1'b1);
    check("first after reset", cmd_valid, 1'b0);
    t_bank();
    t_burst();
    t_mode_set();
    t_power_down();
    t_self_refresh();
    t_async_reset();
    conclude();
  end

  // the whole run needs well under 20 us
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule
